// [src/swe_map.svh]
// Purpose: Shared constants of the single-wire EPROM link
// Assumes: 20 MHz core clock, 1 us timing tick at regular speed
// Notes  : Link times are in microseconds, counted in speed ticks
`ifndef SWE_MAP_SVH
`define SWE_MAP_SVH
// ==========================================================
// Clock and speed ticks
`define SWE_CLK_MHZ     20
`define SWE_OD_DIV      10
`define SWE_TICK_US     1
`define SWE_TICK_STD    (`SWE_CLK_MHZ * `SWE_TICK_US)
`define SWE_TICK_OD     (`SWE_TICK_STD / `SWE_OD_DIV)
// ==========================================================
// Link times in us at regular speed, one tick each
`define SWE_T_RST       480
`define SWE_T_SAMP      15
`define SWE_T_HOLD      30
`define SWE_T_PDW       30
`define SWE_T_PDL       120
`define SWE_T_W0        60
`define SWE_T_W1        2
`define SWE_T_MS        13
`define SWE_T_SLOT      65
`define SWE_T_PRS       70
`define SWE_T_PROG      480
// ==========================================================
// ROM function commands
`define SWE_ROM_READ    8'h33
`define SWE_ROM_MATCH   8'h55
`define SWE_ROM_SEARCH  8'hf0
`define SWE_ROM_SKIP    8'hcc
`define SWE_ROM_ODSKIP  8'h3c
`define SWE_ROM_ODMATCH 8'h69
// ==========================================================
// Memory function commands
`define SWE_MEM_RD      8'hf0
`define SWE_MEM_XRD     8'hc3
`define SWE_MEM_RDST    8'haa
`define SWE_MEM_WR      8'h0f
`define SWE_MEM_WRST    8'h55
// ==========================================================
// Memory layout and codes
`define SWE_MEM_N       8192
`define SWE_MEM_LAST    13'h1fff
`define SWE_STAT_N      352
`define SWE_STAT_GAP    8'h60
`define SWE_STAT_WPR    9'h020
`define SWE_ERASED      8'hff
`define SWE_CRC8_POLY   8'h8c
`define SWE_CRC16_POLY  16'ha001
`endif

// [src/swe_pkg.sv]
// Purpose: Types and CRC helpers of the single-wire EPROM link
// Assumes: swe_map.svh holds all numbers
// Notes  : CRCs are reflected, shifted one bit at a time
`include "swe_map.svh"
package swe_pkg;
   // ==========================================================
   // Device phases
   typedef enum logic [3:0] {
      PH_IDLE   = 4'b0000, PH_ROMCMD = 4'b0001, PH_ROMTX  = 4'b0010,
      PH_MATCH  = 4'b0011, PH_SEARCH = 4'b0100, PH_MEMCMD = 4'b0101,
      PH_ADDR   = 4'b0110, PH_RDDATA = 4'b0111, PH_RDCRC  = 4'b1000,
      PH_WRDATA = 4'b1001, PH_WRCRC  = 4'b1010, PH_PROG   = 4'b1011,
      PH_VERIFY = 4'b1100, PH_ONES   = 4'b1101
   } swe_phase_t;
   // Master states and requests
   typedef enum logic [1:0] {
      MS_IDLE = 2'b00, MS_SLOT = 2'b01, MS_PROG = 2'b10
   } swe_mst_st_t;
   typedef enum logic [2:0] {
      OP_RESET = 3'b000, OP_WBYTE  = 3'b001, OP_RBYTE = 3'b010,
      OP_BIT   = 3'b011, OP_PROG   = 3'b100, OP_SPEED = 3'b101,
      OP_CRCCLR = 3'b110
   } swe_op_t;
   // ==========================================================
   // All registers of each end except the device memory arrays
   typedef struct packed {
      swe_phase_t  ph;
      logic        line_q;
      logic [4:0]  div;
      logic [12:0] lowcnt;
      logic [7:0]  pres;
      logic [5:0]  slot;
      logic        slot_on;
      logic        drv;
      logic        od;
      logic        vpp;
      logic        act;
      logic        ld;
      logic [6:0]  bits;
      logic [1:0]  sub;
      logic [63:0] sh;
      logic [15:0] crc;
      logic [15:0] addr;
      logic [7:0]  cmd;
      logic [7:0]  data;
   } swe_dev_st_t;
   typedef struct packed {
      swe_mst_st_t st;
      swe_op_t     op;
      logic [4:0]  div;
      logic [10:0] cnt;
      logic [7:0]  wb;
      logic [7:0]  rb;
      logic [2:0]  bits;
      logic        od;
      logic        busy;
      logic        done;
      logic        pres;
      logic        oe;
      logic        vpp;
      logic [7:0]  rdata;
      logic [7:0]  crc8;
      logic [15:0] crc16;
   } swe_mst_st_s_t;
   // ==========================================================
   // One CRC step each
   function automatic logic [7:0] swe_crc8(input logic [7:0] c,
                                           input logic b);
      swe_crc8 = (c[0] ^ b) ? ((c >> 1) ^ `SWE_CRC8_POLY) : (c >> 1);
   endfunction
   function automatic logic [15:0] swe_crc16(input logic [15:0] c,
                                             input logic b);
      swe_crc16 = (c[0] ^ b) ? ((c >> 1) ^ `SWE_CRC16_POLY) : (c >> 1);
   endfunction
   // Identity code with its CRC on top
   function automatic logic [63:0] swe_rom_code(input logic [7:0] fam,
                                                input logic [47:0] ser);
      logic [55:0] d;
      logic [7:0]  c;
      d = {ser, fam};
      c = 8'h00;
      for (int i = 0; i < 56; i++)
         c = swe_crc8(c, d[i]);
      swe_rom_code = {c, d};
   endfunction
endpackage

// [src/swe_link_if.sv]
// Purpose: Open-drain single wire plus programming pulse
// Assumes: Pull-up keeps the line high when nobody drives
// Notes  : Resolves both enables into one line level
`timescale 1ns/1ps
interface swe_link_if;
   logic dev_out;
   logic dev_oe;
   logic mst_out;
   logic mst_oe;
   logic vpp;
   logic line;
   // Wired AND of both open-drain drivers
   assign line = ~((dev_oe & ~dev_out) | (mst_oe & ~mst_out));
   modport dev (input line, input vpp, output dev_out, output dev_oe);
   modport mst (input line, output mst_out, output mst_oe, output vpp);
endinterface

// [src/swe_mst.sv]
// Purpose: Bus master end of the single-wire EPROM link
// Assumes: Caller checks returned CRCs before asking for OP_PROG
// Notes  : One request at a time, answered by a done pulse
`timescale 1ns/1ps
`include "swe_map.svh"
module swe_mst
   import swe_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Link
   swe_link_if.mst          link,
   // Request
   input  wire logic        req,
   input  wire swe_op_t     op,
   input  wire logic [7:0]  wdata,
   // Answer
   output logic             busy,
   output logic             done,
   output logic [7:0]       rdata,
   output logic             presence,
   output logic [7:0]       crc8,
   output logic [15:0]      crc16
);
   swe_mst_st_s_t r;
   swe_mst_st_s_t n;
   logic          tick;
   logic          sbit;
   logic [10:0]   t_low;
   logic [10:0]   t_smp;
   logic [10:0]   t_end;

   // ==========================================================
   // Slot shape for the request in progress
   always_comb begin
      sbit = (r.op == OP_RBYTE) | r.wb[0];
      if (r.op == OP_RESET) begin
         t_low = 11'(`SWE_T_RST);
         t_smp = 11'(`SWE_T_RST + `SWE_T_PRS);
         t_end = 11'(2 * `SWE_T_RST);
      end else begin
         t_low = sbit ? 11'(`SWE_T_W1) : 11'(`SWE_T_W0);
         t_smp = 11'(`SWE_T_MS);
         t_end = 11'(`SWE_T_SLOT);
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      n.done = 1'b0;
      tick = (r.div == 5'h00);
      if (tick)
         n.div = r.od ? 5'(`SWE_TICK_OD - 1) : 5'(`SWE_TICK_STD - 1);
      else
         n.div = r.div - 5'h01;
      case (r.st)
         MS_IDLE: if (req) begin
            n.op = op;
            n.wb = wdata;
            n.bits = 3'h0;
            n.cnt = 11'h000;
            n.busy = 1'b1;
            case (op)
               OP_SPEED: begin
                  n.od = wdata[0];
                  n.busy = 1'b0;
                  n.done = 1'b1;
               end
               OP_CRCCLR: begin
                  n.crc8 = 8'h00;
                  n.crc16 = 16'h0000;
                  n.busy = 1'b0;
                  n.done = 1'b1;
               end
               OP_PROG: begin
                  n.st = MS_PROG;
                  n.vpp = 1'b1;
               end
               default: begin
                  n.st = MS_SLOT;
                  n.oe = 1'b1;
               end
            endcase
         end
         MS_SLOT: if (tick) begin
            n.cnt = r.cnt + 11'h001;
            if (r.cnt == t_low)
               n.oe = 1'b0;
            if (r.cnt == t_smp) begin
               if (r.op == OP_RESET)
                  n.pres = ~link.line;
               else begin
                  n.rb = {link.line, r.rb[7:1]};
                  n.crc8 = swe_crc8(r.crc8, link.line);
                  n.crc16 = swe_crc16(r.crc16, link.line);
               end
            end
            if (r.cnt == t_end) begin
               if (r.op != OP_RESET && r.op != OP_BIT
                   && r.bits != 3'h7) begin
                  n.bits = r.bits + 3'h1;
                  n.wb = r.wb >> 1;
                  n.cnt = 11'h000;
                  n.oe = 1'b1;
               end else begin
                  n.st = MS_IDLE;
                  n.busy = 1'b0;
                  n.done = 1'b1;
                  if (r.op == OP_BIT)
                     n.rdata = {7'h00, r.rb[7]};
                  else if (r.op != OP_RESET)
                     n.rdata = r.rb;
               end
            end
         end
         MS_PROG: if (tick) begin
            n.cnt = r.cnt + 11'h001;
            if (r.cnt == 11'(`SWE_T_PROG)) begin
               n.vpp = 1'b0;
               n.st = MS_IDLE;
               n.busy = 1'b0;
               n.done = 1'b1;
            end
         end
         default: n.st = MS_IDLE;
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         r <= '0;
      else
         r <= n;
   end

   // Outputs straight from the state
   assign link.mst_out = 1'b0;
   assign link.mst_oe  = r.oe;
   assign link.vpp     = r.vpp;
   assign busy         = r.busy;
   assign done         = r.done;
   assign rdata        = r.rdata;
   assign presence     = r.pres;
   assign crc8         = r.crc8;
   assign crc16        = r.crc16;
endmodule

// [src/swe_dev.sv]
// Purpose: Device end of the single-wire add-only EPROM carrier
// Assumes: Master follows slot timing; line sampled on core_clk
// Notes  : Memories are erased to all ones by reset
// Functional notes
// - Hold 64-bit family, serial, CRC identity
// - Identity CRC uses x8+x5+x4+1
// - CRC starts zero, family then serial
// - Checker finds zero after shifting CRC
// - No memory function before ROM function
// - Overdrive ROM command switches to fast speed
// - Accept five memory commands after ROM function
// - All bits travel least significant first
// - 256 pages of 32 bytes, random access
// - Scratchpad byte, CRC16 returned before programming
// - Master pulses programming voltage after CRC check
// - Programming only clears bits, AND with old
// - Programming voltage raises an internal flag
// - Separate status memory for protect, redirect
// - Protected page rejects programming, still readable
// - Command byte then address low, high
`timescale 1ns/1ps
`include "swe_map.svh"
module swe_dev
   import swe_pkg::*;
#(
   parameter logic [7:0]  FAMILY = 8'h5a,              // Arbitrary value
   parameter logic [47:0] SERIAL = 48'h0123_4567_89ab  // Arbitrary value
)(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // Link
   swe_link_if.dev   link,
   // Status
   output logic      od_mode,
   output logic      prog_flag,
   output logic      mem_open
);
   // Identity code, family code in the low byte
   localparam logic [63:0] ROM_ID = swe_rom_code(FAMILY, SERIAL);

   swe_dev_st_t r;
   swe_dev_st_t n;
   logic [7:0]  mem_r  [0:`SWE_MEM_N-1];
   logic [7:0]  stat_r [0:`SWE_STAT_N-1];
   logic        tick;
   logic        fall;
   logic        bit_ev;
   logic        bval;
   logic [7:0]  rx8;
   logic [15:0] rx16;
   logic [15:0] crc_nx;
   logic        tx_on;
   logic        tx_bit;
   logic        is_stat;
   logic [7:0]  rd_byte;
   logic [7:0]  wp_byte;
   logic        may_prog;
   logic        mem_we;
   logic        stat_we;

   // ==========================================================
   // Status address decode
   function automatic logic stat_ok(input logic [15:0] a);
      stat_ok = (a[15:9] == 7'h00) && (a[8] || a[7:0] < `SWE_STAT_GAP);
   endfunction
   function automatic logic [8:0] stat_idx(input logic [15:0] a);
      stat_idx = a[8] ? 9'({1'b0, `SWE_STAT_GAP} + {1'b0, a[7:0]})
                      : a[8:0];
   endfunction

   // ==========================================================
   // Byte at the current address and its protection
   always_comb begin
      is_stat = (r.cmd == `SWE_MEM_RDST) || (r.cmd == `SWE_MEM_WRST);
      if (!is_stat)
         rd_byte = mem_r[r.addr[12:0]];
      else if (stat_ok(r.addr))
         rd_byte = stat_r[stat_idx(r.addr)];
      else
         rd_byte = `SWE_ERASED;
      if (!is_stat)
         wp_byte = stat_r[{4'h0, r.addr[12:8]}];
      else
         wp_byte = stat_r[`SWE_STAT_WPR + {4'h0, r.addr[7:3]}];
      if (!is_stat)
         may_prog = wp_byte[r.addr[7:5]];
      else
         may_prog = stat_ok(r.addr) && (!r.addr[8] || wp_byte[r.addr[2:0]]);
   end

   // ==========================================================
   // Bit to drive in the next slot
   always_comb begin
      tx_on = 1'b1;
      tx_bit = r.sh[0];
      case (r.ph)
         PH_ROMTX, PH_RDDATA, PH_RDCRC, PH_WRCRC, PH_VERIFY: ;
         PH_SEARCH: begin
            tx_on = (r.sub != 2'h2);
            tx_bit = r.sub[0] ? ~r.sh[0] : r.sh[0];
         end
         default: tx_on = 1'b0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      bit_ev = 1'b0;
      bval = 1'b0;
      mem_we = 1'b0;
      stat_we = 1'b0;
      tick = (r.div == 5'h00);
      fall = r.line_q && !link.line;
      // Tick divider, rate set by speed mode
      if (tick)
         n.div = r.od ? 5'(`SWE_TICK_OD - 1) : 5'(`SWE_TICK_STD - 1);
      else
         n.div = r.div - 5'h01;
      n.line_q = link.line;
      n.vpp = link.vpp;
      // Low time of the line
      if (fall)
         n.lowcnt = 13'h0000;
      else if (!link.line && tick && r.lowcnt != 13'h1fff)
         n.lowcnt = r.lowcnt + 13'h0001;
      if (r.pres != 8'h00 && tick)
         n.pres = r.pres - 8'h01;
      // Slot start, sample point and release
      if (fall && r.pres == 8'h00) begin
         n.slot_on = 1'b1;
         n.slot = 6'h00;
         n.drv = tx_on & ~tx_bit;
      end else if (r.slot_on && tick) begin
         n.slot = r.slot + 6'h01;
         if (r.slot == 6'(`SWE_T_SAMP)) begin
            bit_ev = 1'b1;
            bval = link.line;
         end
         if (r.slot == 6'(`SWE_T_HOLD)) begin
            n.slot_on = 1'b0;
            n.drv = 1'b0;
         end
      end
      rx8 = {bval, r.sh[63:57]};
      rx16 = {bval, r.sh[63:49]};
      crc_nx = swe_crc16(r.crc, bval);
      // Protocol step on each bit
      if (bit_ev) begin
         n.bits = r.bits + 7'h01;
         n.sh = {bval, r.sh[63:1]};
         if (r.ph == PH_MEMCMD || r.ph == PH_ADDR
             || r.ph == PH_RDDATA || r.ph == PH_WRDATA)
            n.crc = crc_nx;
         case (r.ph)
            PH_ROMCMD: if (r.bits == 7'd7) begin
               n.bits = 7'h00;
               n.sh = ROM_ID;
               n.sub = 2'h0;
               n.crc = 16'h0000;
               case (rx8)
                  `SWE_ROM_READ:   n.ph = PH_ROMTX;
                  `SWE_ROM_MATCH:  n.ph = PH_MATCH;
                  `SWE_ROM_SEARCH: n.ph = PH_SEARCH;
                  `SWE_ROM_SKIP:   n.ph = PH_MEMCMD;
                  `SWE_ROM_ODSKIP: begin
                     n.ph = PH_MEMCMD;
                     n.od = 1'b1;
                  end
                  `SWE_ROM_ODMATCH: begin
                     n.ph = PH_MATCH;
                     n.od = 1'b1;
                  end
                  default: n.ph = PH_IDLE;
               endcase
            end
            PH_ROMTX: if (r.bits == 7'd63) begin
               n.bits = 7'h00;
               n.ph = PH_MEMCMD;
            end
            PH_MATCH: begin
               if (bval != r.sh[0])
                  n.ph = PH_IDLE;
               else if (r.bits == 7'd63) begin
                  n.bits = 7'h00;
                  n.ph = PH_MEMCMD;
               end
            end
            PH_SEARCH: begin
               if (r.sub != 2'h2) begin
                  n.sh = r.sh;
                  n.bits = r.bits;
                  n.sub = r.sub + 2'h1;
               end else begin
                  n.sub = 2'h0;
                  if (bval != r.sh[0])
                     n.ph = PH_IDLE;
                  else if (r.bits == 7'd63) begin
                     n.bits = 7'h00;
                     n.ph = PH_MEMCMD;
                  end
               end
            end
            PH_MEMCMD: if (r.bits == 7'd7) begin
               n.bits = 7'h00;
               n.cmd = rx8;
               if (rx8 == `SWE_MEM_RD || rx8 == `SWE_MEM_XRD
                   || rx8 == `SWE_MEM_RDST || rx8 == `SWE_MEM_WR
                   || rx8 == `SWE_MEM_WRST) begin
                  n.ph = PH_ADDR;
                  n.act = 1'b1;
               end else
                  n.ph = PH_IDLE;
            end
            PH_ADDR: if (r.bits == 7'd15) begin
               n.bits = 7'h00;
               n.addr = rx16;
               if (r.cmd == `SWE_MEM_WR || r.cmd == `SWE_MEM_WRST)
                  n.ph = PH_WRDATA;
               else begin
                  n.ph = PH_RDDATA;
                  n.ld = 1'b1;
               end
            end
            PH_RDDATA: if (r.bits == 7'd7) begin
               n.bits = 7'h00;
               n.addr = r.addr + 16'h0001;
               if (is_stat ? (r.addr[2:0] == 3'h7)
                           : (r.addr[12:0] == `SWE_MEM_LAST)) begin
                  n.ph = PH_RDCRC;
                  n.sh = {48'h0, crc_nx};
               end else
                  n.ld = 1'b1;
            end
            PH_RDCRC: if (r.bits == 7'd15)
               n.ph = PH_ONES;
            PH_WRDATA: if (r.bits == 7'd7) begin
               n.bits = 7'h00;
               n.data = rx8;
               n.ph = PH_WRCRC;
               n.sh = {48'h0, crc_nx};
            end
            PH_WRCRC: if (r.bits == 7'd15) begin
               n.bits = 7'h00;
               n.ph = PH_PROG;
            end
            PH_VERIFY: if (r.bits == 7'd7)
               n.ph = PH_ONES;
            default: n.bits = 7'h00;
         endcase
      end
      // Fetch the next byte to send
      if (r.ld) begin
         n.ld = 1'b0;
         n.sh = {56'h0, rd_byte};
      end
      // Program once the voltage flag is up
      if (r.ph == PH_PROG && r.vpp) begin
         n.ph = PH_VERIFY;
         n.bits = 7'h00;
         mem_we = may_prog && !is_stat;
         stat_we = may_prog && is_stat;
         n.sh = {56'h0, may_prog ? (rd_byte & r.data) : rd_byte};
      end
      // Bus reset ends everything and starts a presence pulse
      if (!r.line_q && link.line && r.lowcnt >= 13'(`SWE_T_RST)) begin
         n.ph = PH_ROMCMD;
         n.bits = 7'h00;
         n.act = 1'b0;
         n.ld = 1'b0;
         n.slot_on = 1'b0;
         n.pres = 8'(`SWE_T_PDW + `SWE_T_PDL);
         if (r.lowcnt >= 13'(`SWE_T_RST * `SWE_OD_DIV))
            n.od = 1'b0;
      end
      if (n.pres != 8'h00)
         n.drv = (n.pres <= 8'(`SWE_T_PDL));
      else if (r.pres != 8'h00)
         n.drv = 1'b0;
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         r <= '0;
      else
         r <= n;
   end

   // ==========================================================
   // EPROM arrays, programming only clears bits
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `SWE_MEM_N; i++)
            mem_r[i] <= `SWE_ERASED;
         for (int j = 0; j < `SWE_STAT_N; j++)
            stat_r[j] <= `SWE_ERASED;
      end else begin
         if (mem_we)
            mem_r[r.addr[12:0]] <= rd_byte & r.data;
         if (stat_we)
            stat_r[stat_idx(r.addr)] <= rd_byte & r.data;
      end
   end

   // Outputs straight from the state
   assign link.dev_out = 1'b0;
   assign link.dev_oe  = r.drv;
   assign od_mode      = r.od;
   assign prog_flag    = r.vpp;
   assign mem_open     = r.act;
endmodule

// [testbench/swe_link_asserts.sv]
// Purpose: Wire checks between master and device ends
// Assumes: 20 or 2 core cycles per link tick
// Notes  : Counters hold run lengths of line states
`timescale 1ns/1ps
module swe_link_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Link wires
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic mst_out,
   input wire logic mst_oe,
   input wire logic vpp,
   input wire logic line
);
   logic [12:0] hi_r;
   logic [12:0] dev_r;
   logic [14:0] mst_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Saturating run lengths of high line and each pull
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hi_r  <= '1;
         dev_r <= '0;
         mst_r <= '0;
      end else begin
         hi_r  <= line ? hi_r + 13'(!(&hi_r)) : '0;
         dev_r <= dev_oe ? dev_r + 13'(!(&dev_r)) : '0;
         mst_r <= mst_oe ? mst_r + 15'(!(&mst_r)) : '0;
      end
   end
   // Open-drain ends only pull low
   chk_dev_drain: assert property (dev_out == 1'b0)
      else $error("device drives high");
   chk_mst_drain: assert property (mst_out == 1'b0)
      else $error("master drives high");
   // Device pulls in a slot or as presence after a reset
   chk_dev_start: assert property ($rose(dev_oe) |->
      (!$past(line) || hi_r inside {[50:70], [570:630]}))
      else $error("device pull out of place");
   chk_dev_len: assert property (dev_oe |-> dev_r < 13'd2440)
      else $error("device pull too long");
   // Master low times: bit 1, bit 0, bus reset
   chk_mst_len: assert property ($fell(mst_oe) |->
      mst_r inside {[5:24], [41:60], [121:140], [961:980],
      [1201:1220], [9601:9620]})
      else $error("master low time");
   chk_mst_gap: assert property ($rose(mst_oe) |-> hi_r >= 13'd6)
      else $error("master slot gap");
   // Programming pulse
   chk_vpp_hold: assert property ($rose(vpp) |=> vpp)
      else $error("pulse too short");
   chk_vpp_quiet: assert property (vpp |-> !mst_oe && !dev_oe)
      else $error("line pulled under pulse");
endmodule

// [testbench/single_wire_addonly_eprom_front_test.sv]
// Purpose: Master and device ends joined on one link
// Assumes: Device identity set here
// Notes  : Overdrive after the first command keeps the run short
`timescale 1ns/1ps
module single_wire_addonly_eprom_front_test;
   import swe_pkg::*;
   localparam logic [7:0]  FAM = 8'h5a;              // Arbitrary value
   localparam logic [47:0] SER = 48'h0123_4567_89ab; // Arbitrary value
   logic        core_clk = 1'b0;
   logic        arst_n   = 1'b0;
   logic        req      = 1'b0;
   swe_op_t     op       = OP_RESET;
   logic [7:0]  wdata    = 8'h00;
   logic        done, presence, od_mode, mem_open;
   logic [7:0]  rdata, crc8;
   logic [63:0] id;
   int          n_fail, num_checks, cyc;
   // ==========================================================
   // Both ends, link and checker
   swe_link_if link ();
   swe_mst u_swe_mst (.core_clk(core_clk), .arst_n(arst_n), .link(link),
      .req(req), .op(op), .wdata(wdata), .busy(), .done(done),
      .rdata(rdata), .presence(presence), .crc8(crc8), .crc16());
   swe_dev #(.FAMILY(FAM), .SERIAL(SER)) u_swe_dev (.core_clk(core_clk),
      .arst_n(arst_n), .link(link), .od_mode(od_mode), .prog_flag(),
      .mem_open(mem_open));
   swe_link_asserts u_swe_link_asserts (.core_clk(core_clk),
      .arst_n(arst_n), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
      .mst_out(link.mst_out), .mst_oe(link.mst_oe), .vpp(link.vpp),
      .line(link.line));
   // Clock and cycle ceiling
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 120000) begin
         n_fail++;
         end_of_test();
      end
   end
   // ==========================================================
   // Reflected CRC step, compare, requests
   function automatic logic [15:0] step(input logic [15:0] c,
      input logic b, input logic [15:0] p);
      step = (c[0] ^ b) ? ((c >> 1) ^ p) : (c >> 1);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic run(input swe_op_t o, input logic [7:0] d);
      int k = 0;
      @(posedge core_clk);
      req   <= 1'b1;
      op    <= o;
      wdata <= d;
      @(posedge core_clk);
      req <= 1'b0;
      #1;
      while (done !== 1'b1 && k < 30000) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk("done", 16'h0001, 16'(done));
   endtask
   task automatic rb(input logic [7:0] e, input string nm);
      run(OP_RBYTE, 8'hff);
      chk(nm, 16'(e), 16'(rdata));
   endtask
   // Skip, command, address low and high, data, CRC, pulse, result
   task automatic wseq(input logic [31:0] m, input logic [7:0] e);
      logic [15:0] x = 16'h0000;
      run(OP_RESET, 8'h00);
      run(OP_WBYTE, 8'hcc);
      for (int i = 0; i < 32; i++) begin
         x = step(x, m[i], 16'ha001);
      end
      for (int i = 0; i < 4; i++) begin
         run(OP_WBYTE, m[8*i+:8]);
      end
      rb(x[7:0], "crc low");
      rb(x[15:8], "crc high");
      run(OP_PROG, 8'h00);
      rb(e, "result");
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      logic [55:0] d = {SER, FAM};
      logic [15:0] c = 16'h0000;
      for (int i = 0; i < 56; i++) begin
         c = step(c, d[i], 16'h008c);
      end
      id = {c[7:0], d};
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      run(OP_RESET, 8'h00);
      chk("presence", 16'h0001, 16'(presence));
      run(OP_WBYTE, 8'h3c);
      run(OP_SPEED, 8'h01);
      chk("od_mode", 16'h0001, 16'(od_mode));
      run(OP_RESET, 8'h00);
      run(OP_WBYTE, 8'haa);
      rb(8'hff, "no rom step");
      chk("mem_open", 16'h0000, 16'(mem_open));
      run(OP_RESET, 8'h00);
      run(OP_WBYTE, 8'h33);
      run(OP_CRCCLR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         rb(id[8*i+:8], "id byte");
      end
      chk("crc8", 16'h0000, 16'(crc8));
      wseq({8'h5a, 16'h0021, 8'h0f}, 8'h5a);
      wseq({8'h0f, 16'h0021, 8'h0f}, 8'h0a);
      wseq({8'hfd, 16'h0000, 8'h55}, 8'hfd);
      wseq({8'h00, 16'h0022, 8'h0f}, 8'hff);
      run(OP_RESET, 8'h00);
      run(OP_WBYTE, 8'hcc);
      run(OP_WBYTE, 8'hf0);
      run(OP_WBYTE, 8'h21);
      run(OP_WBYTE, 8'h00);
      rb(8'h0a, "read 21");
      rb(8'hff, "read 22");
      chk("mem_open", 16'h0001, 16'(mem_open));
      end_of_test();
   end
endmodule
